//--- rtl/control_pin_mode_select.sv
`timescale 1ns/10ps
`default_nettype none
module control_pin_mode_select
  import cpms_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [7:0]             paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  input  wire logic                   pin_reset,
  input  wire logic                   pin_shift_clock,
  input  wire logic                   serial_data_in,
  input  wire logic                   serial_select_line,
  input  wire logic                   pin_out_enable,
  input  wire logic [1:0]             format_select_pin,
  input  wire logic [SAMPLE_BITS-1:0] sample_word,
  input  wire logic                   sample_valid,
  input  wire logic                   out_of_range,
  output var  logic [SAMPLE_BITS-1:0] data_pins,
  output var  logic                   data_pins_oe,
  output var  logic                   sample_clock_out,
  output var  logic                   range_flag_or_readback_pin,
  output var  logic                   standby_ctrl,
  output var  logic                   select_as_control,
  output var  logic                   irq
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  pin_in_t     pin_raw;
  pin_in_t     pin_s;
  serial_out_t so;

  assign pin_raw = '{reset_level: pin_reset, shift_clock: pin_shift_clock,
                     data_in: serial_data_in, select: serial_select_line,
                     out_enable: pin_out_enable, format: format_select_pin};

  pin_sync #(
    .WIDTH       ($bits(pin_in_t)),
    .RESET_VALUE (PIN_RESET_LEVELS)
  ) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (pin_raw),
    .q     (pin_s)
  );

  serial_port u_serial_port (
    .clk   (pclk),
    .rst_n (presetn),
    .pins  (pin_s),
    .so    (so)
  );

  // ----------------------------------------------------------------
  // Pin mode decode
  // ----------------------------------------------------------------
  logic cmos_mode;
  logic twos_fmt;

  assign cmos_mode         = pin_s.format[1];
  assign twos_fmt          = pin_s.format[0];
  assign standby_ctrl      = pin_s.reset_level & pin_s.data_in;
  assign select_as_control = pin_s.reset_level & pin_s.select;
  // LVDS lanes live elsewhere; this block only drives the CMOS bus
  assign data_pins_oe      = pin_s.out_enable & cmos_mode;

  // ----------------------------------------------------------------
  // Parallel data path
  // ----------------------------------------------------------------
  logic                   capture_en;
  logic [SAMPLE_BITS-1:0] next_data_pins;
  logic                   next_clock_out;
  logic                   ovr_q;
  logic                   next_ovr_q;
  logic                   take;

  function automatic logic [SAMPLE_BITS-1:0] to_out_format(
      input logic [SAMPLE_BITS-1:0] w, input logic twos);
    return twos ? {~w[SAMPLE_BITS-1], w[SAMPLE_BITS-2:0]} : w;
  endfunction

  assign take = sample_valid & capture_en & cmos_mode;

  always_comb begin
    next_data_pins = data_pins;
    next_ovr_q     = ovr_q;
    // Low while new data settles, high one cycle later: host edge is mid-word
    next_clock_out = cmos_mode;
    if (take) begin
      next_data_pins = to_out_format(sample_word, twos_fmt);
      next_clock_out = 1'b0;
    end
    if (sample_valid)
      next_ovr_q = out_of_range;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_pins        <= '0;
      sample_clock_out <= 1'b0;
      ovr_q            <= 1'b0;
    end else begin
      data_pins        <= next_data_pins;
      sample_clock_out <= next_clock_out;
      ovr_q            <= next_ovr_q;
    end
  end

  assign range_flag_or_readback_pin = so.readout ? so.sdout : ovr_q;

  // ----------------------------------------------------------------
  // APB slave and interrupt registers
  // ----------------------------------------------------------------
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] next_irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  logic [IRQ_BITS-1:0] next_irq_mask;
  logic [IRQ_BITS-1:0] irq_set;
  logic                next_capture_en;
  logic                ovr_prev;
  logic                rst_prev;
  logic                wr_en;
  logic                rd_en;
  logic                mapped;

  assign pready = 1'b1;
  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & penable & ~pwrite;
  assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_PIN_STATE) ||
                  (paddr == OFF_IRQ_STATUS) || (paddr == OFF_IRQ_MASK) ||
                  (paddr == OFF_SERIAL_REGS);
  assign pslverr = psel & penable & ~mapped;

  assign irq_set[IRQ_SERIAL_WR]   = so.write_done;
  assign irq_set[IRQ_OVERRANGE]   = ovr_q & ~ovr_prev;
  assign irq_set[IRQ_MODE_CHANGE] = pin_s.reset_level ^ rst_prev;

  always_comb begin
    next_capture_en = capture_en;
    next_irq_mask   = irq_mask;
    next_irq_status = irq_status;
    if (wr_en && paddr == OFF_CTRL)
      next_capture_en = pwdata[0];
    if (wr_en && paddr == OFF_IRQ_MASK)
      next_irq_mask = pwdata[IRQ_BITS-1:0];
    // A new event in the clearing cycle survives the read
    if (rd_en && paddr == OFF_IRQ_STATUS)
      next_irq_status = '0;
    next_irq_status = next_irq_status | irq_set;
  end

  always_comb begin
    prdata = 32'h00000000;
    if (rd_en) begin
      case (paddr)
        OFF_CTRL:        prdata = {31'h00000000, capture_en};
        OFF_PIN_STATE:   prdata = {24'h000000, so.busy, so.readout, pin_s.format,
                                   pin_s.out_enable, pin_s.select, pin_s.data_in,
                                   pin_s.reset_level};
        OFF_IRQ_STATUS:  prdata = {29'h00000000, irq_status};
        OFF_IRQ_MASK:    prdata = {29'h00000000, irq_mask};
        OFF_SERIAL_REGS: prdata = {23'h000000, so.user, so.readout};
        default:         prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_en <= CTRL_CAPTURE_RESET;
      irq_mask   <= IRQ_MASK_RESET;
      irq_status <= IRQ_STATUS_RESET;
      ovr_prev   <= 1'b0;
      rst_prev   <= 1'b0;
    end else begin
      capture_en <= next_capture_en;
      irq_mask   <= next_irq_mask;
      irq_status <= next_irq_status;
      ovr_prev   <= ovr_q;
      rst_prev   <= pin_s.reset_level;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_OE_GATE: assert property (
    !pin_s.out_enable |-> !data_pins_oe)
    else $error("data drivers enabled while output enable low");

  AST_OE_FOLLOW: assert property (
    $rose(pin_s.out_enable) && cmos_mode |-> data_pins_oe)
    else $error("data drivers not enabled with output enable high");

  AST_RANGE_FLAG: assert property (
    !so.readout && sample_valid ##1 !so.readout |->
      range_flag_or_readback_pin == $past(out_of_range))
    else $error("range pin does not show out-of-range flag");

  AST_READBACK: assert property (
    so.readout |-> range_flag_or_readback_pin == so.sdout)
    else $error("range pin does not carry readback data");

  AST_RESET_DEFAULTS: assert property (
    pin_s.reset_level ##1 pin_s.reset_level |->
      so.readout == SREG_READOUT_RESET && so.user == SREG_USER_RESET)
    else $error("registers left off default under reset pin");

  AST_SCLK_IGNORED: assert property (
    pin_s.reset_level [*2] |-> !so.write_done && !so.busy)
    else $error("serial port active while reset pin high");

  AST_STANDBY: assert property (
    pin_s.reset_level |-> standby_ctrl == pin_s.data_in)
    else $error("standby control does not follow data-in pin");

  AST_NO_STANDBY: assert property (
    !pin_s.reset_level |-> !standby_ctrl)
    else $error("standby asserted while serial port active");

  AST_SEL_START: assert property (
    !pin_s.reset_level && !so.busy && !pin_s.select |=> so.busy)
    else $error("port not enabled by select line");

  AST_WORD_OUT: assert property (
    take |=> data_pins == to_out_format($past(sample_word), $past(twos_fmt))
             && !sample_clock_out)
    else $error("parallel word not presented on capture");

  AST_CLOCK_RISE: assert property (
    take ##1 cmos_mode && !take |=> sample_clock_out)
    else $error("output clock does not rise after new word");

  AST_LVDS_IDLE: assert property (
    !cmos_mode |=> !sample_clock_out && $stable(data_pins))
    else $error("CMOS bus moves in LVDS mode");

  AST_IRQ_LEVEL: assert property (
    (|(irq_status & irq_mask)) |-> irq)
    else $error("interrupt output low with unmasked status");

  AST_LVDS_NO_DRIVE: assert property (
    !cmos_mode |-> !data_pins_oe)
    else $error("CMOS drivers enabled in LVDS mode");

  AST_SEL_RELEASE: assert property (
    so.busy && (pin_s.select || pin_s.reset_level) |=> !so.busy)
    else $error("serial port stays busy after select or reset pin high");

  AST_CAPTURE_OFF: assert property (
    sample_valid && !capture_en |=> $stable(data_pins))
    else $error("word presented while capture disabled");

  AST_UNMAPPED_NO_WRITE: assert property (
    wr_en && !mapped |=> $stable(capture_en) && $stable(irq_mask))
    else $error("write to unmapped offset changed a register");

  // Clear and set in one cycle: the new event must survive
  AST_IRQ_CLEAR: assert property (
    rd_en && paddr == OFF_IRQ_STATUS |=> irq_status == $past(irq_set))
    else $error("status read did not clear the sticky bits");

  AST_IRQ_SET: assert property (
    (|irq_set) |=> (irq_status & $past(irq_set)) == $past(irq_set))
    else $error("event lost in status register");

  AST_IRQ_STICKY: assert property (
    !(rd_en && paddr == OFF_IRQ_STATUS) |=>
      (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("status bit dropped without a read");

  AST_OVR_EVENT: assert property (
    ovr_q && !ovr_prev |=> irq_status[IRQ_OVERRANGE])
    else $error("out-of-range rise not recorded");

  COV_CMOS_WORD:  cover property (take ##1 data_pins_oe);
  COV_LVDS_SMP:   cover property (sample_valid && !cmos_mode);
  COV_SERIAL_WR:  cover property (so.write_done);
  COV_READBACK:   cover property (so.readout && so.busy);
  COV_MODE_CHG:   cover property ($rose(pin_s.reset_level));

endmodule
`default_nettype wire

//--- rtl/cpms_pkg.sv
package cpms_pkg;

  // ----------------------------------------------------------------
  // Register map, APB side
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_PIN_STATE   = 8'h04;
  localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h08;
  localparam logic [7:0]  OFF_IRQ_MASK    = 8'h0C;
  localparam logic [7:0]  OFF_SERIAL_REGS = 8'h10;

  localparam logic        CTRL_CAPTURE_RESET = 1'h1;
  localparam int          IRQ_BITS           = 3;
  localparam logic [2:0]  IRQ_MASK_RESET     = 3'h0;
  localparam logic [2:0]  IRQ_STATUS_RESET   = 3'h0;
  localparam int          IRQ_SERIAL_WR      = 0;
  localparam int          IRQ_OVERRANGE      = 1;
  localparam int          IRQ_MODE_CHANGE    = 2;

  // ----------------------------------------------------------------
  // Serial configuration port
  // ----------------------------------------------------------------
  localparam logic [4:0]  FRAME_LAST_BIT   = 5'h0F;
  localparam logic [4:0]  ADDR_LAST_BIT    = 5'h07;
  localparam logic [4:0]  READ_SHIFT_FROM  = 5'h09;
  localparam logic [7:0]  SREG_ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  SREG_ADDR_USER   = 8'h01;
  localparam int          SREG_READOUT_BIT = 0;
  localparam int          SREG_SOFT_RST_BIT = 1;
  localparam logic        SREG_READOUT_RESET = 1'h0;
  localparam logic [7:0]  SREG_USER_RESET  = 8'h00;

  localparam int          SAMPLE_BITS = 12;

  typedef struct packed {
    logic       reset_level;
    logic       shift_clock;
    logic       data_in;
    logic       select;
    logic       out_enable;
    logic [1:0] format;      // [0] twos complement, [1] CMOS interface
  } pin_in_t;

  // Synchroniser reset follows the pin pulls, so no false frame start after reset
  localparam pin_in_t PIN_RESET_LEVELS = '{reset_level: 1'b0, shift_clock: 1'b0,
                                           data_in: 1'b0, select: 1'b1,
                                           out_enable: 1'b1, format: 2'h0};

  typedef struct packed {
    logic       readout;
    logic [7:0] user;
    logic       sdout;
    logic       write_done;
    logic       busy;
  } serial_out_t;

  typedef enum logic [2:0] {
    SP_IDLE  = 3'b001,
    SP_SHIFT = 3'b010,
    SP_HOLD  = 3'b100
  } sp_state_t;

endpackage

//--- rtl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // Only the second stage is ever read downstream
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RESET_VALUE;
      q    <= RESET_VALUE;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule
`default_nettype wire

//--- rtl/serial_port.sv
`timescale 1ns/10ps
`default_nettype none
module serial_port
  import cpms_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire pin_in_t     pins,
  output var  serial_out_t so
);

  sp_state_t   state;
  sp_state_t   next_state;
  logic [4:0]  bit_cnt;
  logic [4:0]  next_bit_cnt;
  logic [15:0] shift;
  logic [15:0] next_shift;
  logic [7:0]  rd_shift;
  logic [7:0]  next_rd_shift;
  logic        readout;
  logic        next_readout;
  logic [7:0]  user;
  logic [7:0]  next_user;
  logic        sclk_prev;
  logic        write_done;
  logic [7:0]  wr_byte;
  logic        rise;
  logic        fall;

  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic ro,
                                          input logic [7:0] u);
    if (a == SREG_ADDR_CTRL)
      return {7'h00, ro};
    else if (a == SREG_ADDR_USER)
      return u;
    else
      return 8'h00;
  endfunction

  assign rise = pins.shift_clock & ~sclk_prev;
  assign fall = ~pins.shift_clock & sclk_prev;
  // Last eight bits in, including the one arriving on this edge
  assign wr_byte = {shift[6:0], pins.data_in};

  always_comb begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_shift    = shift;
    next_rd_shift = rd_shift;
    next_readout  = readout;
    next_user     = user;
    write_done    = 1'b0;
    if (pins.reset_level) begin
      // Registers pinned at defaults, shift clock and select ignored
      next_state   = SP_IDLE;
      next_bit_cnt = 5'h00;
      next_readout = SREG_READOUT_RESET;
      next_user    = SREG_USER_RESET;
    end else begin
      case (state)
        SP_IDLE: begin
          if (!pins.select) begin
            next_state   = SP_SHIFT;
            next_bit_cnt = 5'h00;
          end
        end
        SP_SHIFT: begin
          if (pins.select) begin
            // Frame cut short: nothing is written
            next_state = SP_IDLE;
          end else if (rise) begin
            next_shift   = {shift[14:0], pins.data_in};
            next_bit_cnt = bit_cnt + 5'h01;
            if (bit_cnt == ADDR_LAST_BIT)
              next_rd_shift = reg_read(wr_byte, readout, user);
            if (bit_cnt == FRAME_LAST_BIT) begin
              next_state = SP_HOLD;
              write_done = 1'b1;
              // While readback is on, only the control register accepts data
              if (shift[14:7] == SREG_ADDR_CTRL) begin
                next_readout = wr_byte[SREG_READOUT_BIT];
                if (wr_byte[SREG_SOFT_RST_BIT]) begin
                  next_readout = SREG_READOUT_RESET;
                  next_user    = SREG_USER_RESET;
                end
              end else if (shift[14:7] == SREG_ADDR_USER && !readout) begin
                next_user = wr_byte;
              end
            end
          end else if (fall && bit_cnt >= READ_SHIFT_FROM) begin
            next_rd_shift = {rd_shift[6:0], 1'b0};
          end
        end
        SP_HOLD: begin
          if (pins.select)
            next_state = SP_IDLE;
        end
        default: next_state = SP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= SP_IDLE;
      bit_cnt   <= 5'h00;
      shift     <= 16'h0000;
      rd_shift  <= 8'h00;
      readout   <= SREG_READOUT_RESET;
      user      <= SREG_USER_RESET;
      sclk_prev <= 1'b0;
    end else begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shift     <= next_shift;
      rd_shift  <= next_rd_shift;
      readout   <= next_readout;
      user      <= next_user;
      sclk_prev <= pins.shift_clock;
    end
  end

  assign so = '{readout: readout, user: user, sdout: rd_shift[7],
                write_done: write_done, busy: (state != SP_IDLE)};

endmodule
`default_nettype wire

//--- tb/host_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module host_ctrl (
  input  wire logic pclk,
  input  wire logic range_pin,
  output var  logic pin_reset,
  output var  logic shift_clock,
  output var  logic data_in,
  output var  logic select_n
);
  // ----------------------------------------------------------------
  // Idle levels follow the pin pulls: clock low, data low, select high
  // ----------------------------------------------------------------
  initial begin
    pin_reset   = 1'b0;
    shift_clock = 1'b0;
    data_in     = 1'b0;
    select_n    = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // 16-bit frame, half period 20 pclk gives a 160 ns link clock
  task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic [7:0] rb);
    logic [15:0] w;
    w  = {a, d};
    rb = 8'h00;
    select_n <= 1'b0;
    wait_cyc(20);
    for (int i = 15; i >= 0; i--) begin
      data_in <= w[i];
      wait_cyc(20);
      if (i < 8) begin
        rb[i] = range_pin;
      end
      // Clock held at ground while the reset pin is high
      shift_clock <= !pin_reset;
      wait_cyc(20);
      shift_clock <= 1'b0;
    end
    wait_cyc(20);
    data_in  <= 1'b0;
    select_n <= 1'b1;
    wait_cyc(20);
  endtask

  task automatic reset_pulse();
    pin_reset <= 1'b1;
    wait_cyc(10);
    pin_reset <= 1'b0;
    wait_cyc(10);
  endtask

  task automatic levels(input logic r, input logic d, input logic s);
    pin_reset <= r;
    data_in   <= d;
    select_n  <= s;
    wait_cyc(6);
  endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import cpms_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pin_reset, sclk, sdin, seln, oe, svalid, oor, e;
  logic [1:0] fmt;
  logic [11:0] sword, dpins;
  logic doe, clk_out, rpin, standby, selc, irq;
  logic [7:0] rb;
  logic [31:0] seed;
  int fails, compares, cyc, exp_st, prev, last;

  control_pin_mode_select i_dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .pin_reset, .pin_shift_clock(sclk), .serial_data_in(sdin),
    .serial_select_line(seln), .pin_out_enable(oe), .format_select_pin(fmt),
    .sample_word(sword), .sample_valid(svalid), .out_of_range(oor), .data_pins(dpins),
    .data_pins_oe(doe), .sample_clock_out(clk_out), .range_flag_or_readback_pin(rpin),
    .standby_ctrl(standby), .select_as_control(selc), .irq
  );

  host_ctrl host (
    .pclk, .range_pin(rpin), .pin_reset, .shift_clock(sclk), .data_in(sdin),
    .select_n(seln)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, r);
  endtask

  task automatic settle();
    repeat (4) @(posedge pclk);
    #1;
  endtask

  task automatic pulse(input logic [11:0] w, input logic o);
    @(posedge pclk);
    sword  <= w;
    oor    <= o;
    svalid <= 1'b1;
    @(posedge pclk);
    svalid <= 1'b0;
    #1;
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; oe = 1'b1; fmt = 2'h2; sword = 12'h000; svalid = 1'b0; oor = 1'b0;
    seed = 32'd56; fails = 0; compares = 0; cyc = 0; exp_st = 0; prev = 0; last = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CTRL, 32'h1, "ctrl");
    rd(OFF_IRQ_MASK, 32'h0, "irq_mask");
    rd(OFF_IRQ_STATUS, 32'h0, "irq_status");
    apb(1'b1, OFF_PIN_STATE, 32'hFF);
    rd(OFF_PIN_STATE, 32'h2C, "pin_state");
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, r);
    apb(1'b1, 8'h20, 32'h0);
    chk("unmapped_wr_err", 32'h1, {31'h0, e});
    $display("test reset_values done");
    apb(1'b1, OFF_IRQ_MASK, 32'h7);
    host.frame(8'h01, 8'hA5, rb);
    rd(OFF_SERIAL_REGS, 32'h14A, "serial_regs");
    chk("irq", 32'h1, {31'h0, irq});
    rd(OFF_IRQ_STATUS, 32'h1, "irq_status");
    rd(OFF_IRQ_STATUS, 32'h0, "irq_status");
    $display("test serial_write done");
    host.levels(1'b1, 1'b1, 1'b1);
    chk("standby", 32'h1, {31'h0, standby});
    chk("select_ctrl", 32'h1, {31'h0, selc});
    rd(OFF_PIN_STATE, 32'h2F, "pin_state");
    host.frame(8'h01, 8'h3C, rb);
    host.levels(1'b0, 1'b0, 1'b1);
    chk("standby", 32'h0, {31'h0, standby});
    chk("select_ctrl", 32'h0, {31'h0, selc});
    rd(OFF_SERIAL_REGS, 32'h0, "serial_regs");
    rd(OFF_IRQ_STATUS, 32'h4, "irq_status");
    $display("test reset_high done");
    host.reset_pulse();
    host.frame(8'h01, 8'h5A, rb);
    host.frame(8'h00, 8'h01, rb);
    host.frame(8'h01, 8'h77, rb);
    chk("readback", 32'h5A, {24'h0, rb});
    rd(OFF_SERIAL_REGS, 32'hB5, "serial_regs");
    host.frame(8'h00, 8'h02, rb);
    rd(OFF_SERIAL_REGS, 32'h0, "serial_regs");
    rd(OFF_IRQ_STATUS, 32'h5, "irq_status");
    $display("test readback done");
    for (int k = 0; k < 8; k++) begin
      @(posedge pclk);
      fmt <= (k % 2 == 1) ? 2'h3 : 2'h2;
      settle();
      seed = xs();
      pulse(seed[11:0], seed[12] | (k == 0));
      last = seed[11:0] ^ ((k % 2 == 1) ? 12'h800 : 12'h000);
      chk("data_pins", last, {20'h0, dpins});
      chk("clock_low", 32'h0, {31'h0, clk_out});
      @(posedge pclk);
      #1;
      chk("clock_high", 32'h1, {31'h0, clk_out});
      chk("word_at_rise", last, {20'h0, dpins});
      chk("range_pin", {31'h0, oor}, {31'h0, rpin});
      if (oor && prev == 0) begin
        exp_st = exp_st | 2;
      end
      prev = oor;
    end
    @(posedge pclk);
    fmt <= 2'h0;
    settle();
    pulse(12'hFFF, prev[0]);
    settle();
    chk("lvds_data", last, {20'h0, dpins});
    chk("lvds_oe", 32'h0, {31'h0, doe});
    chk("lvds_clock", 32'h0, {31'h0, clk_out});
    @(posedge pclk);
    fmt <= 2'h2;
    apb(1'b1, OFF_CTRL, 32'h0);
    pulse(12'h123, prev[0]);
    settle();
    chk("capture_off", last, {20'h0, dpins});
    apb(1'b1, OFF_CTRL, 32'h1);
    oe <= 1'b0;
    settle();
    chk("oe_low", 32'h0, {31'h0, doe});
    @(posedge pclk);
    oe <= 1'b1;
    settle();
    chk("oe_high", 32'h1, {31'h0, doe});
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_IRQ_MASK, 32'h0);
    settle();
    chk("irq_masked", 32'h0, {31'h0, irq});
    rd(OFF_IRQ_STATUS, exp_st, "irq_status");
    rd(OFF_IRQ_STATUS, 32'h0, "irq_status");
    $display("test parallel_data done");
    test_done();
  end
endmodule
`default_nettype wire
